// file: hw/dmr_pkg.sv
package dmr_pkg;
    // ************************************************
    // Clock and timing
    // ************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    // Least times round up to whole cycles
    localparam int HOLD_NS = 300;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int SPIKE_NS = 100;
    localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
    localparam int PHASE_NS = 4700;
    localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam int HALF_CYC = PHASE_CYC / 2;
    // Longest time rounds down
    localparam int WR_MS = 10;
    localparam int WR_CYC = WR_MS * (CLK_HZ / 1000);
    localparam int BUSY_W = 19;
    localparam int PH_W = 8;
    localparam int FLT_W = 3;
    localparam int HOLD_W = 5;

    // ************************************************
    // Array and framing
    // ************************************************
    localparam int ARRAY_DEPTH = 128;
    localparam int AW = 7;
    localparam logic [AW-1:0] ADDR_ZERO = 7'h00;
    localparam logic [7:0] INIT_PATTERN = 8'h5a;
    localparam logic [3:0] SYNC_CLOCKS = 4'h9;
    localparam logic [3:0] NULL_SLOT = 4'h8;
    localparam logic [3:0] MSB_POS = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [6:0] DEV_CODE = 7'h50;

    // ************************************************
    // Pin indices of the device filter
    // ************************************************
    localparam int PIN_STREAM = 0;
    localparam int PIN_SCL = 1;
    localparam int PIN_SDA = 2;
endpackage

// file: hw/dmr_link_if.sv
`timescale 1ns/10ps
interface dmr_link_if;
    logic stream_clock;
    logic host_scl_oe;
    logic host_sda_oe;
    logic dev_sda_oe;
    logic dev_stream_oe;
    logic dev_stream_bit;
    logic dev_stream_gate;
    logic scl_line;
    logic sda_line;

    // ************************************************
    // Wire levels, pull-ups on both lines
    // ************************************************
    assign scl_line = ~host_scl_oe;
    assign sda_line = ((dev_stream_gate & dev_stream_oe) ?
                       dev_stream_bit : 1'b1) & ~dev_sda_oe & ~host_sda_oe;

    modport dev (
        input stream_clock,
        input scl_line,
        input sda_line,
        output dev_sda_oe,
        output dev_stream_oe,
        output dev_stream_bit,
        output dev_stream_gate
    );

    modport host (
        output stream_clock,
        output host_scl_oe,
        output host_sda_oe,
        input scl_line,
        input sda_line
    );
endinterface

// file: hw/dmr_device.sv
`timescale 1ns/10ps
// Contract
// - Power-up in stream mode, pointer zero
// - Valid bus clock fall enters bidirectional mode
// - Bidirectional mode is left only by power
// - Stream byte is eight bits plus null
// - New stream bit each stream clock rise
// - Stream bytes go out MSB first
// - Ascending addresses, wrap to zero, no pause
// - Host holds bus clock high for stream
// - Nine sync clocks, data output released
// - Tenth rise gives MSB of address zero
// - Bidirectional mode ignores stream clock except writes
// - Master makes clock, START, STOP; device slave
// - Answer only own seven-bit code, any direction
// - Master starts only on idle bus
// - Data changes with clock low; else condition
// - Both lines high means bus idle
// - START is data fall, clock high
// - Hold driven data after clock fall
// - STOP is data rise, clock high
// - Eighth address bit selects direction
// - No acknowledge during programming cycle
// - Stream clock high enables writes, low blocks
module dmr_device #(
    parameter int WR_CYCLE_CYC = dmr_pkg::WR_CYC
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    dmr_link_if.dev link,
    input wire logic wr_req_in,
    input wire logic [dmr_pkg::AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    output logic wr_accept_out,
    output logic bidir_mode_out,
    output logic busy_out,
    output logic start_out,
    output logic stop_out,
    output logic addr_hit_out,
    output logic rw_out
);
    import dmr_pkg::*;

    typedef enum logic [3:0] {
        SL_IDLE = 4'h1,
        SL_ADDR = 4'h2,
        SL_ACK = 4'h4,
        SL_SKIP = 4'h8
    } dmr_slave_t;

    function automatic logic [7:0] init_byte(input int idx);
        init_byte = 8'(idx) ^ INIT_PATTERN;
    endfunction

    // ************************************************
    // Array, quasi-static: written only in bidirectional mode
    // ************************************************
    logic [7:0] mem [ARRAY_DEPTH];
    logic wr_ok;

    initial begin
        for (int i = 0; i < ARRAY_DEPTH; i++) begin
            mem[i] = init_byte(i);
        end
    end

    always_ff @(posedge clock_in) begin
        if (clk_en_in && wr_ok) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // ************************************************
    // Stream side, on the stream clock
    // ************************************************
    logic mode_s1;
    logic mode_s2;
    logic [3:0] sync_cnt;
    logic [3:0] bit_pos;
    logic [AW-1:0] ptr;
    logic st_oe;
    logic st_bit;
    logic [3:0] next_sync_cnt;
    logic [3:0] next_bit_pos;
    logic [AW-1:0] next_ptr;
    logic next_st_oe;
    logic next_st_bit;

    always_comb begin
        next_sync_cnt = sync_cnt;
        next_bit_pos = bit_pos;
        next_ptr = ptr;
        next_st_oe = st_oe;
        next_st_bit = st_bit;
        if (mode_s2) begin
            next_st_oe = 1'b0;
        end else if (sync_cnt < SYNC_CLOCKS) begin
            next_sync_cnt = sync_cnt + 4'h1;
            next_st_oe = 1'b0;
        end else if (bit_pos == NULL_SLOT) begin
            next_st_oe = 1'b0;
            next_bit_pos = 4'h0;
            next_ptr = ptr + 7'h01;
        end else begin
            next_st_oe = 1'b1;
            next_st_bit = mem[ptr][3'(MSB_POS - bit_pos)];
            next_bit_pos = bit_pos + 4'h1;
        end
    end

    // Power-on reset is the only reset the stream side has
    always_ff @(posedge link.stream_clock or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_s1 <= 1'b0;
            mode_s2 <= 1'b0;
            sync_cnt <= 4'h0;
            bit_pos <= 4'h0;
            ptr <= ADDR_ZERO;
            st_oe <= 1'b0;
            st_bit <= 1'b1;
        end else begin
            mode_s1 <= bidir_mode_out;
            mode_s2 <= mode_s1;
            sync_cnt <= next_sync_cnt;
            bit_pos <= next_bit_pos;
            ptr <= next_ptr;
            st_oe <= next_st_oe;
            st_bit <= next_st_bit;
        end
    end

    assign link.dev_stream_oe = st_oe;
    assign link.dev_stream_bit = st_bit;

    // ************************************************
    // Pin synchronisers and spike filters
    // ************************************************
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] filt;
    logic [2:0] filt_d;
    logic [FLT_W-1:0] fcnt [3];
    logic [2:0] next_filt;
    logic [FLT_W-1:0] next_fcnt [3];

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_filt[i] = filt[i];
            next_fcnt[i] = '0;
            if (pin_s2[i] != filt[i]) begin
                next_fcnt[i] = fcnt[i] + 3'h1;
                if (fcnt[i] == FLT_W'(SPIKE_CYC - 1)) begin
                    next_filt[i] = pin_s2[i];
                    next_fcnt[i] = '0;
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_s1 <= 3'h7;
            pin_s2 <= 3'h7;
            filt <= 3'h7;
            filt_d <= 3'h7;
            for (int i = 0; i < 3; i++) begin
                fcnt[i] <= '0;
            end
        end else if (clk_en_in) begin
            pin_s1 <= {link.sda_line, link.scl_line, link.stream_clock};
            pin_s2 <= pin_s1;
            filt <= next_filt;
            filt_d <= filt;
            fcnt <= next_fcnt;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise = filt[PIN_SCL] & ~filt_d[PIN_SCL];
    assign scl_fall = ~filt[PIN_SCL] & filt_d[PIN_SCL];
    // Data edge with clock steady high is a condition
    assign bus_start = filt[PIN_SCL] & filt_d[PIN_SCL] &
                       filt_d[PIN_SDA] & ~filt[PIN_SDA];
    assign bus_stop = filt[PIN_SCL] & filt_d[PIN_SCL] &
                      ~filt_d[PIN_SDA] & filt[PIN_SDA];

    // ************************************************
    // Mode, slave front end and programming cycle
    // ************************************************
    dmr_slave_t sl;
    dmr_slave_t next_sl;
    logic [7:0] sreg;
    logic [3:0] bcnt;
    logic [HOLD_W-1:0] hold;
    logic [BUSY_W-1:0] busy_cnt;
    logic next_bidir;
    logic [7:0] next_sreg;
    logic [3:0] next_bcnt;
    logic [HOLD_W-1:0] next_hold;
    logic [BUSY_W-1:0] next_busy_cnt;
    logic next_sda_oe;
    logic next_hit;
    logic next_rw;

    // Writes need the stream clock high and no cycle running
    assign wr_ok = wr_req_in & bidir_mode_out & filt[PIN_STREAM] &
                   ~busy_out;

    always_comb begin
        next_bidir = bidir_mode_out | scl_fall;
        next_sl = sl;
        next_sreg = sreg;
        next_bcnt = bcnt;
        next_hold = (hold != '0) ? hold - 5'h01 : hold;
        next_busy_cnt = (busy_cnt != '0) ? busy_cnt - 19'h00001 : busy_cnt;
        next_sda_oe = link.dev_sda_oe;
        next_hit = 1'b0;
        next_rw = rw_out;
        if (wr_ok) begin
            next_busy_cnt = BUSY_W'(WR_CYCLE_CYC);
        end
        if (bus_stop) begin
            next_sl = SL_IDLE;
            next_sda_oe = 1'b0;
        end else if (bus_start) begin
            next_sl = SL_ADDR;
            next_bcnt = 4'h0;
            next_sda_oe = 1'b0;
        end else begin
            unique case (sl)
                SL_IDLE: begin
                end
                SL_ADDR: begin
                    if (scl_rise) begin
                        next_sreg = {sreg[6:0], filt[PIN_SDA]};
                        next_bcnt = bcnt + 4'h1;
                    end else if (scl_fall && bcnt == ACK_SLOT) begin
                        if (sreg[7:1] == DEV_CODE && bidir_mode_out &&
                            !busy_out) begin
                            next_sl = SL_ACK;
                            next_hit = 1'b1;
                            next_rw = sreg[0];
                            next_hold = HOLD_W'(HOLD_CYC);
                        end else begin
                            next_sl = SL_SKIP;
                        end
                    end
                end
                SL_ACK: begin
                    if (hold == '0) begin
                        next_sda_oe = 1'b1;
                    end
                    if (scl_fall) begin
                        next_sl = SL_SKIP;
                        next_hold = HOLD_W'(HOLD_CYC);
                    end
                end
                SL_SKIP: begin
                    if (hold == '0) begin
                        next_sda_oe = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bidir_mode_out <= 1'b0;
            link.dev_stream_gate <= 1'b1;
            sl <= SL_IDLE;
            sreg <= 8'h00;
            bcnt <= 4'h0;
            hold <= '0;
            busy_cnt <= '0;
            busy_out <= 1'b0;
            link.dev_sda_oe <= 1'b0;
            wr_accept_out <= 1'b0;
            start_out <= 1'b0;
            stop_out <= 1'b0;
            addr_hit_out <= 1'b0;
            rw_out <= 1'b0;
        end else if (clk_en_in) begin
            bidir_mode_out <= next_bidir;
            link.dev_stream_gate <= ~next_bidir;
            sl <= next_sl;
            sreg <= next_sreg;
            bcnt <= next_bcnt;
            hold <= next_hold;
            busy_cnt <= next_busy_cnt;
            busy_out <= next_busy_cnt != '0;
            link.dev_sda_oe <= next_sda_oe;
            wr_accept_out <= wr_ok;
            start_out <= bus_start;
            stop_out <= bus_stop;
            addr_hit_out <= next_hit;
            rw_out <= next_rw;
        end
    end
endmodule

// file: hw/dmr_host.sv
`timescale 1ns/10ps
module dmr_host (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    dmr_link_if.host link,
    input wire logic go_in,
    input wire logic [6:0] dev_code_in,
    input wire logic rw_in,
    output logic busy_out,
    output logic done_out,
    output logic ack_out,
    output logic stream_bit_out,
    output logic stream_valid_out
);
    import dmr_pkg::*;

    typedef enum logic [7:0] {
        H_STREAM = 8'h01,
        H_SW_LO = 8'h02,
        H_SW_HI = 8'h04,
        H_IDLE = 8'h08,
        H_START = 8'h10,
        H_BIT_LO = 8'h20,
        H_BIT_HI = 8'h40,
        H_STOP = 8'h80
    } dmr_host_t;

    // ************************************************
    // Command sequencer and stream clock divider
    // ************************************************
    dmr_host_t st;
    dmr_host_t next_st;
    logic [PH_W-1:0] ph;
    logic [PH_W-1:0] next_ph;
    logic [8:0] shreg;
    logic [8:0] next_shreg;
    logic [3:0] bcnt;
    logic [3:0] next_bcnt;
    logic [3:0] rises;
    logic [3:0] next_rises;
    logic [3:0] pos;
    logic [3:0] next_pos;
    logic sda_s1;
    logic sda_s2;
    logic next_stream_clock;
    logic next_scl_oe;
    logic next_sda_oe;
    logic next_done;
    logic next_ack;
    logic next_sbit;
    logic next_svalid;
    logic ph_end;

    assign ph_end = ph == PH_W'(PHASE_CYC - 1);

    always_comb begin
        next_st = st;
        next_ph = ph_end ? '0 : ph + 8'h01;
        next_shreg = shreg;
        next_bcnt = bcnt;
        next_rises = rises;
        next_pos = pos;
        next_stream_clock = link.stream_clock;
        next_scl_oe = link.host_scl_oe;
        next_sda_oe = link.host_sda_oe;
        next_done = 1'b0;
        next_ack = ack_out;
        next_sbit = stream_bit_out;
        next_svalid = 1'b0;
        unique case (st)
            H_STREAM: begin
                next_scl_oe = 1'b0;
                if (go_in) begin
                    next_st = H_SW_LO;
                    next_ph = '0;
                    // Stream clock parks low, device moves only on rises
                    next_stream_clock = 1'b0;
                    next_shreg = {dev_code_in, rw_in, 1'b1};
                end else if (ph_end) begin
                    next_stream_clock = ~link.stream_clock;
                    // Counts the tenth rise too, the first carrying data
                    if (!link.stream_clock && rises <= SYNC_CLOCKS) begin
                        next_rises = rises + 4'h1;
                    end
                    // Sample at the falling edge, half a period after change
                    if (link.stream_clock && rises > SYNC_CLOCKS) begin
                        next_pos = (pos == NULL_SLOT) ? 4'h0 : pos + 4'h1;
                        next_sbit = sda_s2;
                        next_svalid = pos != NULL_SLOT;
                    end
                end
            end
            H_SW_LO: begin
                next_scl_oe = 1'b1;
                // Two rises flush the device's mode synchroniser
                if (ph == PH_W'(HALF_CYC)) begin
                    next_stream_clock = 1'b1;
                end
                if (ph_end) begin
                    next_st = H_SW_HI;
                    next_stream_clock = 1'b0;
                end
            end
            H_SW_HI: begin
                next_scl_oe = 1'b0;
                if (ph == PH_W'(HALF_CYC)) begin
                    next_stream_clock = 1'b1;
                end
                if (ph_end) begin
                    next_st = H_START;
                    next_stream_clock = 1'b0;
                end
            end
            H_IDLE: begin
                // A go inside the free phase after STOP is dropped
                if (bcnt != 4'h0) begin
                    if (!sda_s2) begin
                        next_ph = '0;
                    end else if (ph_end) begin
                        next_bcnt = 4'h0;
                    end
                end else if (go_in) begin
                    next_st = H_START;
                    next_ph = '0;
                    next_shreg = {dev_code_in, rw_in, 1'b1};
                end
            end
            H_START: begin
                next_sda_oe = 1'b1;
                next_bcnt = 4'h0;
                if (ph == PH_W'(HALF_CYC)) begin
                    next_stream_clock = 1'b1;
                end
                if (ph_end) begin
                    next_st = H_BIT_LO;
                    next_scl_oe = 1'b1;
                end
            end
            H_BIT_LO: begin
                next_scl_oe = 1'b1;
                if (ph == PH_W'(HALF_CYC)) begin
                    next_sda_oe = ~shreg[8];
                end
                if (ph_end) begin
                    next_st = H_BIT_HI;
                    next_scl_oe = 1'b0;
                end
            end
            H_BIT_HI: begin
                if (ph_end) begin
                    next_scl_oe = 1'b1;
                    next_shreg = {shreg[7:0], 1'b1};
                    next_bcnt = bcnt + 4'h1;
                    next_st = H_BIT_LO;
                    if (bcnt == ACK_SLOT) begin
                        next_ack = ~sda_s2;
                        next_st = H_STOP;
                    end
                end
            end
            H_STOP: begin
                if (ph == PH_W'(HALF_CYC)) begin
                    next_sda_oe = 1'b1;
                end
                if (ph_end) begin
                    if (link.host_scl_oe) begin
                        next_scl_oe = 1'b0;
                    end else begin
                        next_sda_oe = 1'b0;
                        next_st = H_IDLE;
                        next_done = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st <= H_STREAM;
            ph <= '0;
            shreg <= 9'h1ff;
            bcnt <= 4'h0;
            rises <= 4'h0;
            pos <= 4'h0;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            link.stream_clock <= 1'b0;
            link.host_scl_oe <= 1'b0;
            link.host_sda_oe <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            ack_out <= 1'b0;
            stream_bit_out <= 1'b1;
            stream_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            st <= next_st;
            ph <= next_ph;
            shreg <= next_shreg;
            bcnt <= next_bcnt;
            rises <= next_rises;
            pos <= next_pos;
            sda_s1 <= link.sda_line;
            sda_s2 <= sda_s1;
            link.stream_clock <= next_stream_clock;
            link.host_scl_oe <= next_scl_oe;
            link.host_sda_oe <= next_sda_oe;
            busy_out <= next_st != H_STREAM &&
                (next_st != H_IDLE || next_bcnt != 4'h0);
            done_out <= next_done;
            ack_out <= next_ack;
            stream_bit_out <= next_sbit;
            stream_valid_out <= next_svalid;
        end
    end
endmodule

// file: verif/dmr_link_properties.sv
`timescale 1ns/10ps
module dmr_link_properties
    import dmr_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic stream_clock,
    input wire logic dev_sda_oe,
    input wire logic dev_stream_oe,
    input wire logic dev_stream_bit,
    input wire logic dev_stream_gate,
    input wire logic scl_line
);
    // ****
    // Stream reference, kept apart from the device
    // ****
    logic [3:0] rises, next_rises;
    logic [3:0] slot, next_slot;
    logic [AW-1:0] ptr, next_ptr;
    logic [7:0] exp_byte;
    logic [4:0] low_cnt, next_low_cnt;
    logic run;

    assign run = rises == 4'ha;
    assign exp_byte = {1'b0, ptr} ^ INIT_PATTERN;
    always_comb begin
        next_rises = run ? rises : rises + 4'h1;
        next_slot = (!run || slot == NULL_SLOT) ? 4'h0 : slot + 4'h1;
        next_ptr = !run ? ADDR_ZERO : ptr + AW'(slot == NULL_SLOT);
        next_low_cnt = scl_line ? 5'h00 : low_cnt + 5'(low_cnt != 5'h1f);
    end
    always_ff @(posedge stream_clock or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rises <= 4'h0;
            slot <= 4'h0;
            ptr <= ADDR_ZERO;
        end else begin
            rises <= next_rises;
            slot <= next_slot;
            ptr <= next_ptr;
        end
    end
    // Saturates so long low phases never wrap to a false short one
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            low_cnt <= 5'h00;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end

    property p_sync_quiet;
        @(posedge stream_clock) disable iff (!reset_n_in)
        rises <= SYNC_CLOCKS |-> !dev_stream_oe;
    endproperty
    a_sync_quiet: assert property (p_sync_quiet)
        else $error("stream output driven during sync");
    property p_first_bit;
        @(posedge stream_clock) disable iff (!reset_n_in)
        run && slot == 4'h0 && ptr == ADDR_ZERO && dev_stream_gate
        |-> dev_stream_oe && dev_stream_bit == INIT_PATTERN[7];
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first stream bit wrong");
    property p_null;
        @(posedge stream_clock) disable iff (!reset_n_in)
        run && slot == NULL_SLOT && dev_stream_gate |-> !dev_stream_oe;
    endproperty
    a_null: assert property (p_null)
        else $error("null slot driven");
    property p_data_slot;
        @(posedge stream_clock) disable iff (!reset_n_in)
        run && slot != NULL_SLOT && dev_stream_gate |-> dev_stream_oe;
    endproperty
    a_data_slot: assert property (p_data_slot)
        else $error("data slot not driven");
    property p_msb_first;
        @(posedge stream_clock) disable iff (!reset_n_in)
        run && slot != NULL_SLOT && dev_stream_gate
        |-> dev_stream_bit == exp_byte[3'(MSB_POS - slot)];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("stream bit out of order");
    property p_sticky;
        @(posedge clock_in) disable iff (!reset_n_in)
        !dev_stream_gate |=> !dev_stream_gate;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("stream mode came back");
    property p_switch;
        @(posedge clock_in) disable iff (!reset_n_in)
        $fell(scl_line) && dev_stream_gate |-> ##[1:20] !dev_stream_gate;
    endproperty
    a_switch: assert property (p_switch)
        else $error("no switch after bus clock fall");
    property p_gate_cause;
        @(posedge clock_in) disable iff (!reset_n_in)
        $fell(dev_stream_gate) |-> !$past(scl_line, 4);
    endproperty
    a_gate_cause: assert property (p_gate_cause)
        else $error("switch without bus clock fall");
    property p_hold;
        @(posedge clock_in) disable iff (!reset_n_in)
        $changed(dev_sda_oe) |-> !scl_line && low_cnt >= 5'(HOLD_CYC);
    endproperty
    a_hold: assert property (p_hold)
        else $error("data changed too early after clock fall");
    property p_high_stable;
        @(posedge clock_in) disable iff (!reset_n_in)
        scl_line && $past(scl_line) |-> $stable(dev_sda_oe);
    endproperty
    a_high_stable: assert property (p_high_stable)
        else $error("data changed while clock high");

    c_first_bit: cover property (@(posedge stream_clock) run && slot == 4'h0);
    c_switch: cover property (@(posedge clock_in) $fell(dev_stream_gate));
    c_ack: cover property (@(posedge clock_in) $rose(dev_sda_oe));
endmodule

// file: verif/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    import dmr_pkg::*;
    logic clock_in, reset_n_in, go_in, rw_in, wr_req_in;
    logic [6:0] dev_code_in;
    logic [AW-1:0] wr_addr_in;
    logic [7:0] wr_data_in;
    logic wr_acc, bidir, dbusy, start_p, stop_p, rw_o, done, ack, sbit, sval;
    logic hbusy, hit;
    int error_cnt = 0;
    int num_checks = 0;
    int n_start = 0;
    int n_stop = 0;
    int n_hit = 0;
    logic stream_q[$];
    logic a;

    dmr_link_if link();
    dmr_device #(.WR_CYCLE_CYC(8000)) i_dmr_device(.clock_in(clock_in),
        .reset_n_in(reset_n_in), .clk_en_in(1'b1), .link(link.dev),
        .wr_req_in(wr_req_in), .wr_addr_in(wr_addr_in),
        .wr_data_in(wr_data_in), .wr_accept_out(wr_acc),
        .bidir_mode_out(bidir), .busy_out(dbusy), .start_out(start_p),
        .stop_out(stop_p), .addr_hit_out(hit), .rw_out(rw_o));
    dmr_host i_dmr_host(.clock_in(clock_in), .reset_n_in(reset_n_in),
        .clk_en_in(1'b1), .link(link.host), .go_in(go_in),
        .dev_code_in(dev_code_in), .rw_in(rw_in), .busy_out(hbusy),
        .done_out(done), .ack_out(ack), .stream_bit_out(sbit),
        .stream_valid_out(sval));
    dmr_link_properties i_props(.clock_in(clock_in), .reset_n_in(reset_n_in),
        .stream_clock(link.stream_clock), .dev_sda_oe(link.dev_sda_oe),
        .dev_stream_oe(link.dev_stream_oe),
        .dev_stream_bit(link.dev_stream_bit),
        .dev_stream_gate(link.dev_stream_gate), .scl_line(link.scl_line));

    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        if (sval) stream_q.push_back(sbit);
        if (start_p) n_start++;
        if (stop_p) n_stop++;
        if (hit) n_hit++;
    end

    task give_verdict;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Gives up after a bound, so a dead handshake ends the run
    task cmd(input logic [6:0] code, input logic rw, output logic got);
        int s0, p0, h0, i;
        s0 = n_start;
        p0 = n_stop;
        h0 = n_hit;
        go_in <= 1'b1;
        dev_code_in <= code;
        rw_in <= rw;
        @(posedge clock_in);
        go_in <= 1'b0;
        for (i = 0; i < 30000 && done !== 1'b1; i++) @(posedge clock_in);
        if (done !== 1'b1) begin error_cnt++; give_verdict(); end
        got = ack;
        for (i = 0; i < 1000 && hbusy !== 1'b0; i++) @(posedge clock_in);
        `CHK(hbusy, 1'b0)
        if (hbusy !== 1'b0) give_verdict();
        `CHK(n_start - s0, 1)
        `CHK(n_stop - p0, 1)
        `CHK(n_hit - h0, int'(got))
    endtask
    task t_stream;
        int i;
        logic [7:0] b;
        for (i = 0; i < 25000 && stream_q.size() < 24; i++) @(posedge clock_in);
        `CHK(stream_q.size() >= 24, 1'b1)
        if (stream_q.size() < 24) give_verdict();
        for (i = 0; i < 24 && i < stream_q.size(); i++) begin
            b = {1'b0, 7'(i / 8)} ^ INIT_PATTERN;
            `CHK(stream_q[i], b[7 - i % 8])
        end
        `CHK(bidir, 1'b0)
        `CHK(link.dev_stream_gate, 1'b1)
    endtask
    task t_mode;
        cmd(DEV_CODE, 1'b0, a);
        `CHK(a, 1'b1)
        `CHK(bidir, 1'b1)
        `CHK(rw_o, 1'b0)
        `CHK(link.dev_stream_oe, 1'b0)
        cmd(DEV_CODE, 1'b1, a);
        `CHK(a, 1'b1)
        `CHK(rw_o, 1'b1)
    endtask
    task t_wrong;
        cmd(DEV_CODE ^ 7'h01, 1'b0, a);
        `CHK(a, 1'b0)
        cmd(DEV_CODE ^ 7'h40, 1'b1, a);
        `CHK(a, 1'b0)
    endtask
    task t_busy;
        int i;
        wr_req_in <= 1'b1;
        wr_addr_in <= 7'h10;
        wr_data_in <= 8'ha5;
        for (i = 0; i < 100 && wr_acc !== 1'b1; i++) @(posedge clock_in);
        wr_req_in <= 1'b0;
        `CHK(wr_acc, 1'b1)
        if (wr_acc !== 1'b1) give_verdict();
        cmd(DEV_CODE, 1'b0, a);
        `CHK(a, 1'b0)
        for (i = 0; i < 20000 && dbusy !== 1'b0; i++) @(posedge clock_in);
        `CHK(dbusy, 1'b0)
        if (dbusy !== 1'b0) give_verdict();
        cmd(DEV_CODE, 1'b0, a);
        `CHK(a, 1'b1)
        `CHK(bidir, 1'b1)
    endtask

    initial begin
        reset_n_in = 1'b0;
        go_in = 1'b0;
        rw_in = 1'b0;
        dev_code_in = 7'h00;
        wr_req_in = 1'b0;
        wr_addr_in = 7'h00;
        wr_data_in = 8'h00;
        repeat (16) @(posedge clock_in);
        reset_n_in <= 1'b1;
        t_stream();
        t_mode();
        t_wrong();
        t_busy();
        give_verdict();
    end
endmodule
